// file: src/ddig_regs.svh
// Purpose: Register offsets, reset values and field positions of the descriptor-done grouping block
// Assumes: Byte addresses on the controller's internal register port
// Notes:   Definitions only
`ifndef DDIG_REGS_SVH
`define DDIG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DDIG_ISO_ANY_DONE_MASK_OFS      16'h0318
`define DDIG_PERIODIC_ANY_DONE_MASK_OFS 16'h031c
`define DDIG_ASYNC_ANY_DONE_MASK_OFS    16'h0320
`define DDIG_ISO_ALL_DONE_MASK_OFS      16'h0324
`define DDIG_PERIODIC_ALL_DONE_MASK_OFS 16'h0328
`define DDIG_ASYNC_ALL_DONE_MASK_OFS    16'h032c

// ----------------------------------------------------------------
// Reset values and enable bit positions
// ----------------------------------------------------------------
`define DDIG_MASK_RESET                 32'h0000_0000
`define DDIG_UNMAPPED_READ              32'h0000_0000
`define DDIG_ISO_IRQ_ENABLE_BIT         9
`define DDIG_ASYNC_IRQ_ENABLE_BIT       8
`define DDIG_PERIODIC_IRQ_ENABLE_BIT    7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DDIG_UFRAME_US                  125
`define DDIG_CLK_MHZ                    100
`define DDIG_UFRAME_CYCLES              (`DDIG_UFRAME_US * `DDIG_CLK_MHZ)

`endif

// file: src/ddig_pkg.sv
// Purpose: Types shared by the descriptor-done grouping block
// Assumes: 32 descriptors per schedule type
// Notes:   Constants live in ddig_regs.svh
package ddig_pkg;

   typedef logic [31:0] ddig_map_t;

   // Done maps of the three schedule types
   typedef struct packed {
      ddig_map_t iso;
      ddig_map_t periodic;
      ddig_map_t async_list;
   } ddig_done_t;

   // One flag per schedule type
   typedef struct packed {
      logic iso;
      logic periodic;
      logic async_list;
   } ddig_flags_t;

   typedef enum logic [1:0] {
      DDIG_GRANT_NONE,
      DDIG_GRANT_ISO,
      DDIG_GRANT_PERIODIC,
      DDIG_GRANT_ASYNC
   } ddig_grant_t;

endpackage

// file: src/ddig_irq_group.sv
// Purpose: Groups transfer_descriptor completions into interrupt requests per schedule type
// Assumes: Register port and done maps come from logic on clk; microframe tick comes on clk
// Notes:   Six any/all done masks, per-type enables, microframe latency, schedule order
//
// Notes on behaviour
// - The isochronous any-done mask is 32-bit read-write, one bit per descriptor, reset zero.
// - The periodic any-done mask is 32-bit read-write, one bit per descriptor, reset zero.
// - The async_list any-done mask is 32-bit read-write, one bit per descriptor, reset zero.
// - The isochronous all-done mask is 32-bit read-write, reset zero, a clear bit excluded.
// - The periodic all-done mask is 32-bit read-write, reset zero, one bit per descriptor.
// - The async_list all-done mask is 32-bit read-write, reset zero, one bit per descriptor.
// - Each schedule type carries at most 32 descriptors, each a memory-to-bus channel.
// - With scheduling on, isochronous runs first, then periodic, then async_list.
// - A descriptor is complete while its done bit is true and feeds its type's mask logic.
// - Completion reaches software as interrupts grouped by the any and all masks per type.
// - Four sources exist (iso, periodic, async_list, start of frame), latency in microframes.
// - Isochronous matches raise the request only while enable bit 9 is 1.
// - Async_list matches need enable bit 8 and periodic matches need enable bit 7.
`include "ddig_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ddig_irq_group (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Register port
   input  wire logic                reg_cs,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [15:0]         reg_addr,
   input  wire logic [31:0]         reg_wdata,
   output logic      [31:0]         reg_rdata,
   // Completion and enables
   input  wire ddig_pkg::ddig_done_t done_map,
   input  wire logic [31:0]         irq_enable,
   input  wire logic                sof_irq_enable,
   // Microframe timing
   input  wire logic                uframe_tick,
   input  wire logic [3:0]          irq_latency_uframes,
   // Scheduling
   input  wire logic                sched_enable,
   input  wire ddig_pkg::ddig_flags_t sched_request,
   output ddig_pkg::ddig_grant_t    sched_grant,
   // Interrupt
   input  wire logic                irq_ack,
   output ddig_pkg::ddig_flags_t    group_event,
   output ddig_pkg::ddig_flags_t    source_pending,
   output logic                     sof_pending,
   output logic                     irq
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic group_match(input logic [31:0] done,
                                        input logic [31:0] any_mask,
                                        input logic [31:0] all_mask);
      logic any_hit;
      logic all_hit;
      any_hit = |(done & any_mask);
      all_hit = (all_mask != 32'h0000_0000) && ((done & all_mask) == all_mask);
      return any_hit | all_hit;
   endfunction

   function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] ofs);
      return reg_cs && (addr == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Mask registers
   // ----------------------------------------------------------------
   logic [31:0] iso_any_done_mask_reg;
   logic [31:0] periodic_any_done_mask_reg;
   logic [31:0] async_any_done_mask_reg;
   logic [31:0] iso_all_done_mask_reg;
   logic [31:0] periodic_all_done_mask_reg;
   logic [31:0] async_all_done_mask_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         iso_any_done_mask_reg      <= `DDIG_MASK_RESET;
         periodic_any_done_mask_reg <= `DDIG_MASK_RESET;
         async_any_done_mask_reg    <= `DDIG_MASK_RESET;
         iso_all_done_mask_reg      <= `DDIG_MASK_RESET;
         periodic_all_done_mask_reg <= `DDIG_MASK_RESET;
         async_all_done_mask_reg    <= `DDIG_MASK_RESET;
      end else if (reg_wr) begin
         if (reg_hit(reg_addr, `DDIG_ISO_ANY_DONE_MASK_OFS)) begin
            iso_any_done_mask_reg <= reg_wdata;
         end
         if (reg_hit(reg_addr, `DDIG_PERIODIC_ANY_DONE_MASK_OFS)) begin
            periodic_any_done_mask_reg <= reg_wdata;
         end
         if (reg_hit(reg_addr, `DDIG_ASYNC_ANY_DONE_MASK_OFS)) begin
            async_any_done_mask_reg <= reg_wdata;
         end
         if (reg_hit(reg_addr, `DDIG_ISO_ALL_DONE_MASK_OFS)) begin
            iso_all_done_mask_reg <= reg_wdata;
         end
         if (reg_hit(reg_addr, `DDIG_PERIODIC_ALL_DONE_MASK_OFS)) begin
            periodic_all_done_mask_reg <= reg_wdata;
         end
         if (reg_hit(reg_addr, `DDIG_ASYNC_ALL_DONE_MASK_OFS)) begin
            async_all_done_mask_reg <= reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data, registered one cycle after the read strobe
   // ----------------------------------------------------------------
   logic [31:0] rdata_next;

   always_comb begin
      rdata_next = `DDIG_UNMAPPED_READ;
      if (reg_cs && reg_rd) begin
         case (reg_addr)
            `DDIG_ISO_ANY_DONE_MASK_OFS:      rdata_next = iso_any_done_mask_reg;
            `DDIG_PERIODIC_ANY_DONE_MASK_OFS: rdata_next = periodic_any_done_mask_reg;
            `DDIG_ASYNC_ANY_DONE_MASK_OFS:    rdata_next = async_any_done_mask_reg;
            `DDIG_ISO_ALL_DONE_MASK_OFS:      rdata_next = iso_all_done_mask_reg;
            `DDIG_PERIODIC_ALL_DONE_MASK_OFS: rdata_next = periodic_all_done_mask_reg;
            `DDIG_ASYNC_ALL_DONE_MASK_OFS:    rdata_next = async_all_done_mask_reg;
            default:                          rdata_next = `DDIG_UNMAPPED_READ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= `DDIG_UNMAPPED_READ;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Group match, checked each cycle against live masks and done map
   // ----------------------------------------------------------------
   ddig_pkg::ddig_flags_t match_next;

   always_comb begin
      match_next.iso        = group_match(done_map.iso, iso_any_done_mask_reg,
                                          iso_all_done_mask_reg);
      match_next.periodic   = group_match(done_map.periodic, periodic_any_done_mask_reg,
                                          periodic_all_done_mask_reg);
      match_next.async_list = group_match(done_map.async_list, async_any_done_mask_reg,
                                          async_all_done_mask_reg);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         group_event <= '0;
      end else begin
         group_event <= match_next;
      end
   end

   // ----------------------------------------------------------------
   // Sticky sources; a new event beats an acknowledge in the same cycle
   // ----------------------------------------------------------------
   ddig_pkg::ddig_flags_t enabled_event;

   always_comb begin
      enabled_event.iso        = group_event.iso &
                                 irq_enable[`DDIG_ISO_IRQ_ENABLE_BIT];
      enabled_event.async_list = group_event.async_list &
                                 irq_enable[`DDIG_ASYNC_IRQ_ENABLE_BIT];
      enabled_event.periodic   = group_event.periodic &
                                 irq_enable[`DDIG_PERIODIC_IRQ_ENABLE_BIT];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         source_pending <= '0;
         sof_pending    <= 1'b0;
      end else begin
         source_pending <= enabled_event | (irq_ack ? '0 : source_pending);
         sof_pending    <= (uframe_tick & sof_irq_enable) |
                           (~irq_ack & sof_pending);
      end
   end

   // ----------------------------------------------------------------
   // Latency in whole microframes since the last acknowledge
   // ----------------------------------------------------------------
   logic [3:0] uframe_cnt_reg;
   logic       latency_met;

   assign latency_met = (uframe_cnt_reg >= irq_latency_uframes);

   always_ff @(posedge clk) begin
      if (rst || irq_ack) begin
         uframe_cnt_reg <= 4'h0;
      end else if (uframe_tick && !latency_met) begin
         uframe_cnt_reg <= uframe_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= ((|source_pending) | sof_pending) & latency_met & ~irq_ack;
      end
   end

   // ----------------------------------------------------------------
   // Schedule order: isochronous, then periodic, then async_list
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sched_grant <= ddig_pkg::DDIG_GRANT_NONE;
      end else if (!sched_enable) begin
         sched_grant <= ddig_pkg::DDIG_GRANT_NONE;
      end else if (sched_request.iso) begin
         sched_grant <= ddig_pkg::DDIG_GRANT_ISO;
      end else if (sched_request.periodic) begin
         sched_grant <= ddig_pkg::DDIG_GRANT_PERIODIC;
      end else if (sched_request.async_list) begin
         sched_grant <= ddig_pkg::DDIG_GRANT_ASYNC;
      end else begin
         sched_grant <= ddig_pkg::DDIG_GRANT_NONE;
      end
   end

endmodule

`default_nettype wire

// file: tb/ddig_irq_group_properties.sv
// Purpose: Port assertions for ddig_irq_group
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the test top file
`include "ddig_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module ddig_irq_group_props (
   // Clock, reset and register port
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  reg_cs,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [15:0]           reg_addr,
   input wire logic [31:0]           reg_wdata,
   input wire logic [31:0]           reg_rdata,
   // Completion, interrupt and scheduling
   input wire ddig_pkg::ddig_done_t  done_map,
   input wire logic [31:0]           irq_enable,
   input wire logic                  irq_ack,
   input wire ddig_pkg::ddig_flags_t group_event,
   input wire ddig_pkg::ddig_flags_t source_pending,
   input wire logic                  sof_pending,
   input wire logic                  irq,
   input wire logic                  sched_enable,
   input wire ddig_pkg::ddig_flags_t sched_request,
   input wire ddig_pkg::ddig_grant_t sched_grant
);
   // -------------------------------------------------------------
   // Mirror of the isochronous any-done mask
   // -------------------------------------------------------------
   logic [31:0] iso_any_reg;
   always_ff @(posedge clk) begin
      if (rst)
         iso_any_reg <= 32'h0000_0000;
      else if (reg_cs && reg_wr && reg_addr == `DDIG_ISO_ANY_DONE_MASK_OFS)
         iso_any_reg <= reg_wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!(reg_cs && reg_rd) |=> reg_rdata == 32'h0000_0000)
      else $error("read data not zero when idle");
   a_unmapped_read: assert property (reg_cs && reg_rd && reg_addr > 16'h032c
      |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
   a_any_match: assert property (|(done_map.iso & iso_any_reg) |=> group_event.iso)
      else $error("iso any-done match gave no event");
   a_iso_gated: assert property ($rose(source_pending.iso) |-> $past(irq_enable[9]))
      else $error("iso pending set while disabled");
   a_async_gated: assert property ($rose(source_pending.async_list) |-> $past(irq_enable[8]))
      else $error("async pending set while disabled");
   a_ack_drops_irq: assert property (irq_ack |=> !irq)
      else $error("irq stayed up after ack");
   a_irq_cause: assert property ($rose(irq) |-> $past(source_pending) != 3'h0 || $past(sof_pending))
      else $error("irq rose with nothing pending");
   a_sched_off: assert property (!sched_enable |=> sched_grant == ddig_pkg::DDIG_GRANT_NONE)
      else $error("grant while scheduling off");
   a_sched_iso: assert property (sched_enable && sched_request.iso |=> sched_grant == 2'h1)
      else $error("iso not granted first");
endmodule
`default_nettype wire

// file: tb/ddig_irq_group_test.sv
// Purpose: Directed test of ddig_irq_group
// Assumes: Inputs driven on the falling edge
// Notes:   Start-of-frame source exercised last
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module ddig_irq_group_test;
   logic                  clk, rst, reg_cs, reg_wr, reg_rd, sof_irq_enable, uframe_tick;
   logic                  sched_enable, irq_ack, sof_pending, irq;
   logic [15:0]           reg_addr;
   logic [31:0]           reg_wdata, reg_rdata, irq_enable;
   logic [3:0]            irq_latency_uframes;
   ddig_pkg::ddig_done_t  done_map;
   ddig_pkg::ddig_flags_t sched_request, group_event, source_pending;
   ddig_pkg::ddig_grant_t sched_grant;
   int                    failures, n_checks;
   ddig_irq_group u_dut (.clk, .rst, .reg_cs, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .done_map, .irq_enable, .sof_irq_enable, .uframe_tick, .irq_latency_uframes,
      .sched_enable, .sched_request, .sched_grant, .irq_ack, .group_event, .source_pending,
      .sof_pending, .irq);
   // -------------------------------------------------------------
   // Bus cycles
   // -------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'h3, a, d};
      @(negedge clk);
      {reg_cs, reg_wr} = 2'h0;
      @(negedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] ex);
      {reg_cs, reg_rd, reg_addr} = {2'h3, a};
      @(negedge clk);
      `CHK("reg_rdata", ex, reg_rdata)
      {reg_cs, reg_rd} = 2'h0;
      @(negedge clk);
   endtask
   task automatic ack;
      irq_ack = 1'b1;
      @(negedge clk);
      irq_ack = 1'b0;
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_regs;
      for (int i = 0; i < 6; i++) rd(16'h0318 + 16'(4 * i), 32'h0000_0000);
      for (int i = 0; i < 6; i++) wr(16'h0318 + 16'(4 * i), {16'ha5c3, 16'(i)});
      for (int i = 0; i < 6; i++) rd(16'h0318 + 16'(4 * i), {16'ha5c3, 16'(i)});
      wr(16'h0330, 32'hffff_ffff);
      rd(16'h0330, 32'h0000_0000);
      for (int i = 0; i < 6; i++) wr(16'h0318 + 16'(4 * i), 32'h0000_0000);
   endtask
   task automatic t_any(input int k);
      irq_enable = 32'h0000_0000;
      wr(16'h0318 + 16'(4 * k), 32'h8000_0000);
      done_map = 96'h1 << (95 - 32 * k);
      @(negedge clk);
      `CHK("group_event", 3'h4 >> k, group_event)
      repeat (2) @(negedge clk);
      `CHK("source_pending", 3'h0, source_pending)
      irq_enable[k == 0 ? 9 : k == 1 ? 7 : 8] = 1'b1;
      repeat (3) @(negedge clk);
      `CHK("source_pending", 3'h4 >> k, source_pending)
      `CHK("irq", 1'b1, irq)
      done_map = '0;
      repeat (2) @(negedge clk);
      ack();
      `CHK("irq_and_pending", 4'h0, {irq, source_pending})
      wr(16'h0318 + 16'(4 * k), 32'h0000_0000);
   endtask
   task automatic t_all(input int k);
      irq_enable = 32'h0000_0000;
      wr(16'h0324 + 16'(4 * k), 32'h0000_0005);
      done_map = 96'h3 << (64 - 32 * k);
      repeat (2) @(negedge clk);
      `CHK("group_event", 3'h0, group_event)
      done_map = 96'h7 << (64 - 32 * k);
      @(negedge clk);
      `CHK("group_event", 3'h4 >> k, group_event)
      wr(16'h0324 + 16'(4 * k), 32'h0000_0000);
      done_map = 96'hffff_ffff << (64 - 32 * k);
      repeat (2) @(negedge clk);
      `CHK("group_event", 3'h0, group_event)
      done_map = '0;
   endtask
   task automatic t_sched;
      sched_enable = 1'b1;
      for (int r = 0; r < 8; r++) begin
         sched_request = 3'(r);
         @(negedge clk);
         `CHK("sched_grant", r[2] ? 2'h1 : r[1] ? 2'h2 : r[0] ? 2'h3 : 2'h0, sched_grant)
      end
      sched_enable = 1'b0;
      @(negedge clk);
      `CHK("sched_grant", 2'h0, sched_grant)
   endtask
   task automatic t_latency;
      {irq_latency_uframes, irq_enable} = {4'h2, 32'h0000_0200};
      wr(16'h0318, 32'h0000_0001);
      done_map = 96'h1 << 64;
      ack();
      repeat (5) @(negedge clk);
      for (int t = 0; t < 2; t++) begin
         `CHK("irq", 1'b0, irq)
         uframe_tick = 1'b1;
         @(negedge clk);
         uframe_tick = 1'b0;
         repeat (3) @(negedge clk);
      end
      `CHK("irq", 1'b1, irq)
   endtask
   task automatic t_sof;
      {done_map, irq_latency_uframes} = 100'h0;
      repeat (2) @(negedge clk);
      ack();
      `CHK("irq_and_pending", 5'h00, {irq, source_pending, sof_pending})
      {sof_irq_enable, uframe_tick} = 2'h3;
      @(negedge clk);
      uframe_tick = 1'b0;
      `CHK("sof_pending", 1'b1, sof_pending)
      @(negedge clk);
      `CHK("irq", 1'b1, irq)
      ack();
      `CHK("sof_pending", 1'b0, sof_pending)
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      report_and_stop();
   end
   initial begin
      {rst, reg_cs, reg_wr, reg_rd, reg_addr, reg_wdata, irq_enable} = {4'h8, 80'h0};
      {sof_irq_enable, uframe_tick, irq_latency_uframes, sched_enable, irq_ack} = 8'h0;
      {done_map, sched_request} = 99'h0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_regs();
      for (int k = 0; k < 3; k++) t_any(k);
      for (int k = 0; k < 3; k++) t_all(k);
      t_sched();
      t_latency();
      t_sof();
      report_and_stop();
   end
endmodule
bind ddig_irq_group ddig_irq_group_props u_props (.clk, .rst, .reg_cs, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .done_map, .irq_enable, .irq_ack, .group_event,
   .source_pending, .sof_pending, .irq, .sched_enable, .sched_request, .sched_grant);
`default_nettype wire
